// File: rtl/splp_pin_logic.sv
// Top of strap decode, indicator drive, shared pin muxing and pair swap
// Summary of operation
// - General-purpose pins come up as inputs
// - Clock strap high makes interrupt active low
// - Select strap high selects 8-bit bus
// - Wake strap sets chip-select polarity, 8-bit
// - GP6 strap sets interrupt open-drain, 8-bit
// - Unfitted strap reads zero; pull-up reads one
// - Speed pin low at 100M, floats 10M
// - 16-bit mode: speed pin may be IO16
// - Link pin: link+carrier mode1, carrier mode0
// - 16-bit mode: link pin may be wait/wake
// - Ready 5 us after reset release
// - Pair roles swap in crossover mode
// - Signal-detect input qualifies fiber receive
// - Indicator mode comes from loaded memory
module splp_pin_logic #(
    parameter int READY_COUNT = splp_pkg::READY_CYCLES
) (
    input  wire logic                   ref_clk_in,
    input  wire logic                   rst_b_in,
    input  wire logic                   clk_strap_in,
    input  wire logic                   sel_strap_in,
    input  wire logic                   wake_strap_in,
    input  wire logic                   gp6_strap_in,
    input  wire logic                   cfg_mem_loaded_in,
    input  wire splp_pkg::splp_mem_cfg_t mem_cfg_in,
    input  wire splp_pkg::splp_phy_stat_t phy_stat_in,
    input  wire logic                   int_req_in,
    input  wire logic                   io16_ack_in,
    input  wire logic                   io_wait_in,
    input  wire logic                   wake_event_in,
    input  wire logic                   gpio_wr_dir_in,
    input  wire logic                   gpio_wr_val_in,
    input  wire logic [2:0]             gpio_wdata_in,
    input  wire logic [2:0]             gpio_pin_in,
    input  wire logic                   crossover_in,
    input  wire logic                   fiber_signal_detect_in,
    input  wire logic                   test_mode_in,
    output splp_pkg::splp_cfg_t         cfg_out,
    output logic                        ready_out,
    output logic                        int_o_out,
    output logic                        int_oe_out,
    output logic                        cs_active_high_out,
    output logic                        speed_indicator_o_out,
    output logic                        speed_indicator_oe_out,
    output logic                        link_activity_indicator_o_out,
    output logic                        link_activity_indicator_oe_out,
    output logic [2:0]                  gpio_o_out,
    output logic [2:0]                  gpio_oe_out,
    output logic [2:0]                  gpio_value_out,
    output logic                        rx_pair_is_tx_out,
    output logic                        tx_pair_is_rx_out,
    output logic                        fiber_rx_valid_out,
    output logic                        test_mode_seen_out
);
    import splp_pkg::*;

    splp_cfg_t      cfg;
    logic           latched;
    logic           ready;

    logic [2:0]     gpio_direction_reg;
    logic [2:0]     gpio_direction_next;
    logic [2:0]     gpio_value_reg;
    logic [2:0]     gpio_value_next;
    logic           led_mode_reg;
    logic           led_mode_next;
    logic           speed_alt_reg;
    logic           speed_alt_next;
    logic [1:0]     link_sel_reg;
    logic [1:0]     link_sel_next;
    splp_pin_drv_t  int_drv_reg;
    splp_pin_drv_t  int_drv_next;
    splp_pin_drv_t  speed_drv_reg;
    splp_pin_drv_t  speed_drv_next;
    splp_pin_drv_t  link_drv_reg;
    splp_pin_drv_t  link_drv_next;
    logic           rx_tx_reg;
    logic           rx_tx_next;
    logic           fiber_reg;
    logic           fiber_next;
    logic           test_reg;
    logic           test_next;

    // Active-low open-drain style drive: low when asserted, float otherwise
    function automatic splp_pin_drv_t pull_low(input logic active);
        pull_low.o  = 1'b0;
        pull_low.oe = active;
    endfunction

    // ****************************************
    // Strap latch and readiness timer
    // ****************************************
    splp_strap_latch u_strap (
        .ref_clk_in    (ref_clk_in),
        .rst_b_in      (rst_b_in),
        .clk_strap_in  (clk_strap_in),
        .sel_strap_in  (sel_strap_in),
        .wake_strap_in (wake_strap_in),
        .gp6_strap_in  (gp6_strap_in),
        .cfg_out       (cfg),
        .latched_out   (latched)
    );

    splp_ready_timer #(
        .READY_COUNT (READY_COUNT)
    ) u_ready (
        .ref_clk_in (ref_clk_in),
        .rst_b_in   (rst_b_in),
        .ready_out  (ready)
    );

    // ****************************************
    // General-purpose pins and memory settings
    // ****************************************
    always_comb begin
        gpio_direction_next = gpio_direction_reg;
        gpio_value_next     = gpio_value_reg;
        led_mode_next       = led_mode_reg;
        speed_alt_next      = speed_alt_reg;
        link_sel_next       = link_sel_reg;
        if (ready && gpio_wr_dir_in) begin
            gpio_direction_next = gpio_wdata_in;
        end
        if (ready && gpio_wr_val_in) begin
            gpio_value_next = gpio_wdata_in;
        end
        if (cfg_mem_loaded_in) begin
            led_mode_next  = mem_cfg_in.led_mode;
            speed_alt_next = mem_cfg_in.speed_pin_alt;
            link_sel_next  = mem_cfg_in.link_pin_sel;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            gpio_direction_reg <= GPIO_DIR_RESET;
            gpio_value_reg     <= GPIO_VAL_RESET;
            led_mode_reg       <= 1'b0;
            speed_alt_reg      <= 1'b0;
            link_sel_reg       <= ALT_LED;
        end else begin
            gpio_direction_reg <= gpio_direction_next;
            gpio_value_reg     <= gpio_value_next;
            led_mode_reg       <= led_mode_next;
            speed_alt_reg      <= speed_alt_next;
            link_sel_reg       <= link_sel_next;
        end
    end

    // ****************************************
    // Pin drive computation
    // ****************************************
    always_comb begin
        int_drv_next   = '{1'b0, 1'b0};
        speed_drv_next = pull_low(phy_stat_in.speed_100);
        link_drv_next  = '{1'b0, 1'b0};
        if (cfg.int_open_drain) begin
            int_drv_next.o  = 1'b0;
            int_drv_next.oe = int_req_in;
        end else begin
            int_drv_next.o  = int_req_in ^ cfg.int_active_low;
            int_drv_next.oe = 1'b1;
        end
        if (led_mode_reg) begin
            link_drv_next = pull_low(phy_stat_in.link_up | phy_stat_in.carrier_sense);
        end else begin
            link_drv_next = pull_low(phy_stat_in.carrier_sense);
        end
        if (!cfg.bus_8bit) begin
            if (speed_alt_reg) begin
                speed_drv_next = pull_low(io16_ack_in);
            end
            if (link_sel_reg == ALT_BUS) begin
                link_drv_next = pull_low(io_wait_in);
            end else if (link_sel_reg == ALT_WAKE) begin
                link_drv_next = '{wake_event_in, 1'b1};
            end
        end
        if (!latched) begin
            int_drv_next   = '{1'b0, 1'b0};
            speed_drv_next = '{1'b0, 1'b0};
            link_drv_next  = '{1'b0, 1'b0};
        end
        rx_tx_next = crossover_in;
        fiber_next = fiber_signal_detect_in;
        test_next  = test_mode_in;
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            int_drv_reg   <= '{1'b0, 1'b0};
            speed_drv_reg <= '{1'b0, 1'b0};
            link_drv_reg  <= '{1'b0, 1'b0};
            rx_tx_reg     <= 1'b0;
            fiber_reg     <= 1'b0;
            test_reg      <= 1'b0;
        end else begin
            int_drv_reg   <= int_drv_next;
            speed_drv_reg <= speed_drv_next;
            link_drv_reg  <= link_drv_next;
            rx_tx_reg     <= rx_tx_next;
            fiber_reg     <= fiber_next;
            test_reg      <= test_next;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign cfg_out                        = cfg;
    assign ready_out                      = ready;
    assign cs_active_high_out             = cfg.cs_active_high;
    assign int_o_out                      = int_drv_reg.o;
    assign int_oe_out                     = int_drv_reg.oe;
    assign speed_indicator_o_out          = speed_drv_reg.o;
    assign speed_indicator_oe_out         = speed_drv_reg.oe;
    assign link_activity_indicator_o_out  = link_drv_reg.o;
    assign link_activity_indicator_oe_out = link_drv_reg.oe;
    assign gpio_o_out                     = gpio_value_reg;
    assign gpio_oe_out                    = gpio_direction_reg;
    assign gpio_value_out                 = (gpio_direction_reg & gpio_value_reg) | (~gpio_direction_reg & gpio_pin_in);
    assign rx_pair_is_tx_out              = rx_tx_reg;
    assign tx_pair_is_rx_out              = rx_tx_reg;
    assign fiber_rx_valid_out             = fiber_reg;
    assign test_mode_seen_out             = test_reg;
endmodule

// File: rtl/splp_pkg.sv
// Package of constants and carrier types for the strap and indicator pin logic
package splp_pkg;

    localparam int          CLK_MHZ          = 250;
    localparam int          READY_DELAY_NS   = 5000;
    localparam int          READY_CYCLES     = (READY_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int          GPIO_COUNT       = 3;
    localparam logic [2:0]  GPIO_DIR_RESET   = 3'h0;
    localparam logic [2:0]  GPIO_VAL_RESET   = 3'h0;
    localparam logic        STRAP_DEFAULT    = 1'b0;
    localparam logic [1:0]  ALT_LED          = 2'h0;
    localparam logic [1:0]  ALT_BUS          = 2'h1;
    localparam logic [1:0]  ALT_WAKE         = 2'h2;

    typedef struct packed {
        logic int_active_low;
        logic bus_8bit;
        logic cs_active_high;
        logic int_open_drain;
    } splp_cfg_t;

    typedef struct packed {
        logic led_mode;
        logic speed_pin_alt;
        logic [1:0] link_pin_sel;
    } splp_mem_cfg_t;

    typedef struct packed {
        logic speed_100;
        logic link_up;
        logic carrier_sense;
        logic full_duplex;
    } splp_phy_stat_t;

    typedef struct packed {
        logic o;
        logic oe;
    } splp_pin_drv_t;

endpackage

// File: rtl/splp_strap_latch.sv
// Strap capture and latch on the first clock edge after power-on reset release
module splp_strap_latch (
    input  wire logic              ref_clk_in,
    input  wire logic              rst_b_in,
    input  wire logic              clk_strap_in,
    input  wire logic              sel_strap_in,
    input  wire logic              wake_strap_in,
    input  wire logic              gp6_strap_in,
    output splp_pkg::splp_cfg_t    cfg_out,
    output logic                   latched_out
);
    import splp_pkg::*;

    splp_cfg_t cfg_reg;
    splp_cfg_t cfg_next;
    logic      latched_reg;
    logic      latched_next;

    // ****************************************
    // Capture once after reset release
    // ****************************************
    always_comb begin
        cfg_next     = cfg_reg;
        latched_next = 1'b1;
        if (!latched_reg) begin
            cfg_next.int_active_low = clk_strap_in;
            cfg_next.bus_8bit       = sel_strap_in;
            cfg_next.cs_active_high = sel_strap_in & wake_strap_in;
            cfg_next.int_open_drain = sel_strap_in & gp6_strap_in;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cfg_reg     <= '{STRAP_DEFAULT, STRAP_DEFAULT, STRAP_DEFAULT, STRAP_DEFAULT};
            latched_reg <= 1'b0;
        end else begin
            cfg_reg     <= cfg_next;
            latched_reg <= latched_next;
        end
    end

    assign cfg_out     = cfg_reg;
    assign latched_out = latched_reg;
endmodule

// File: rtl/splp_ready_timer.sv
// Readiness delay counter after power-on reset release
module splp_ready_timer #(
    parameter int READY_COUNT = splp_pkg::READY_CYCLES
) (
    input  wire logic ref_clk_in,
    input  wire logic rst_b_in,
    output logic      ready_out
);
    import splp_pkg::*;

    localparam int CW = $clog2(READY_COUNT + 1);

    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic          ready_reg;
    logic          ready_next;

    always_comb begin
        count_next = count_reg;
        ready_next = ready_reg;
        if (!ready_reg) begin
            count_next = count_reg + CW'(1);
            ready_next = (count_reg == CW'(READY_COUNT - 1));
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_reg <= '0;
            ready_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            ready_reg <= ready_next;
        end
    end

    assign ready_out = ready_reg;
endmodule

// File: testbench/splp_pin_logic_sva.sv
// Checker of strap, interrupt, indicator and general-purpose pin behaviour
module splp_pin_logic_sva #(
    parameter int READY_COUNT = splp_pkg::READY_CYCLES
) (
    input wire logic                     ref_clk_in,
    input wire logic                     rst_b_in,
    input wire logic                     int_req_in,
    input wire logic                     gpio_wr_dir_in,
    input wire logic [2:0]               gpio_wdata_in,
    input wire logic                     crossover_in,
    input wire logic                     fiber_signal_detect_in,
    input wire splp_pkg::splp_phy_stat_t phy_stat_in,
    input wire splp_pkg::splp_cfg_t      cfg_out,
    input wire logic                     ready_out,
    input wire logic                     int_o_out,
    input wire logic                     int_oe_out,
    input wire logic                     cs_active_high_out,
    input wire logic                     speed_indicator_o_out,
    input wire logic                     speed_indicator_oe_out,
    input wire logic [2:0]               gpio_o_out,
    input wire logic [2:0]               gpio_oe_out,
    input wire logic                     rx_pair_is_tx_out,
    input wire logic                     tx_pair_is_rx_out,
    input wire logic                     fiber_rx_valid_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import splp_pkg::*;
    // ****
    // Edge count since reset release
    // ****
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    always_comb begin
        cnt_next = (cnt_reg == 16'hffff) ? cnt_reg : cnt_reg + 16'h1;
    end
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_reg <= 16'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_b_in);
    a_ready_delay: assert property (ready_out == (32'(cnt_reg) >= READY_COUNT))
        else $error("ready timing wrong");
    a_gpio_come_up: assert property ($rose(ready_out) |-> gpio_oe_out == 3'h0 && gpio_o_out == 3'h0)
        else $error("gpio not input at ready");
    a_gpio_dir_write: assert property (ready_out && gpio_wr_dir_in |=> gpio_oe_out == $past(gpio_wdata_in))
        else $error("gpio direction write lost");
    a_strap_hold: assert property (ready_out |-> $stable(cfg_out))
        else $error("strap config changed");
    a_int_push_pull: assert property (ready_out && !cfg_out.int_open_drain |=>
        int_oe_out && int_o_out == ($past(int_req_in) ^ cfg_out.int_active_low))
        else $error("push-pull interrupt wrong");
    a_int_open_drain: assert property (ready_out && cfg_out.int_open_drain |=>
        !int_o_out && int_oe_out == $past(int_req_in))
        else $error("open-drain interrupt wrong");
    a_cs_polarity: assert property (ready_out |->
        cs_active_high_out == (cfg_out.bus_8bit && cfg_out.cs_active_high))
        else $error("chip select polarity wrong");
    a_speed_led: assert property (ready_out && cfg_out.bus_8bit |=>
        !speed_indicator_o_out && speed_indicator_oe_out == $past(phy_stat_in.speed_100))
        else $error("speed indicator wrong");
    a_pair_swap: assert property (ready_out |=>
        rx_pair_is_tx_out == $past(crossover_in) && tx_pair_is_rx_out == $past(crossover_in))
        else $error("pair roles wrong");
    a_fiber_detect: assert property (ready_out |=> fiber_rx_valid_out == $past(fiber_signal_detect_in))
        else $error("fiber valid wrong");
    c_ready: cover property ($rose(ready_out));
    c_open_drain: cover property (ready_out && cfg_out.int_open_drain && int_oe_out);
    c_dir_write: cover property (ready_out && gpio_wr_dir_in);
endmodule

bind splp_pin_logic splp_pin_logic_sva #(.READY_COUNT(READY_COUNT)) splp_pin_logic_sva_inst (
    .ref_clk_in, .rst_b_in, .int_req_in, .gpio_wr_dir_in, .gpio_wdata_in, .crossover_in,
    .fiber_signal_detect_in, .phy_stat_in, .cfg_out, .ready_out, .int_o_out, .int_oe_out,
    .cs_active_high_out, .speed_indicator_o_out, .speed_indicator_oe_out, .gpio_o_out,
    .gpio_oe_out, .rx_pair_is_tx_out, .tx_pair_is_rx_out, .fiber_rx_valid_out
);

// File: testbench/splp_board.sv
// Board model: strap resistors, configuration memory and test pin tie
module splp_board (
    input  wire logic                    ref_clk_in,
    input  wire logic                    rst_b_in,
    input  wire logic [3:0]              pullup_fit_in,
    input  wire splp_pkg::splp_mem_cfg_t mem_word_in,
    output logic [3:0]                   strap_out,
    output logic                         cfg_mem_loaded_out,
    output splp_pkg::splp_mem_cfg_t      mem_cfg_out,
    output logic                         test_mode_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import splp_pkg::*;
    // ****
    // Pin levels seen by the device
    // ****
    logic [1:0] age_reg;
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            age_reg <= 2'h0;
        end else if (age_reg != 2'h3) begin
            age_reg <= age_reg + 2'h1;
        end
    end
    // Shared pins carry other traffic once latched
    assign strap_out          = age_reg[1] ? ~pullup_fit_in : pullup_fit_in;
    assign cfg_mem_loaded_out = (age_reg == 2'h3);
    assign mem_cfg_out        = cfg_mem_loaded_out ? mem_word_in : ~mem_word_in;
    assign test_mode_out      = 1'b0;
endmodule

// File: testbench/splp_pin_logic_tb.sv
// Self-checking bench of the strap and indicator pin logic
module splp_pin_logic_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import splp_pkg::*;
    localparam int RC = 4;
    logic clk, rst_b, loaded, tmi, irq, io16, iowt, wake, wdir, wval, xo, fsd;
    logic rdy, io, ioe, csh, so, soe, lo, loe, rxt, txr, fv, tms;
    logic [3:0] fit, strap;
    logic [2:0] wd, gpin, go, goe, gdir, gval, gv;
    logic [31:0] r;
    logic [5:0] e;
    splp_mem_cfg_t word, mcfg;
    splp_phy_stat_t phy, ph;
    splp_cfg_t cfg;
    int n_mismatch, total_checks, k;
    // ****
    // Clock, board and device
    // ****
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    splp_board splp_board_inst (.ref_clk_in(clk), .rst_b_in(rst_b), .pullup_fit_in(fit), .mem_word_in(word),
        .strap_out(strap), .cfg_mem_loaded_out(loaded), .mem_cfg_out(mcfg), .test_mode_out(tmi));
    splp_pin_logic #(.READY_COUNT(RC)) splp_pin_logic_inst (
        .ref_clk_in(clk), .rst_b_in(rst_b), .clk_strap_in(strap[3]), .sel_strap_in(strap[2]),
        .wake_strap_in(strap[1]), .gp6_strap_in(strap[0]), .cfg_mem_loaded_in(loaded), .mem_cfg_in(mcfg),
        .phy_stat_in(phy), .int_req_in(irq), .io16_ack_in(io16), .io_wait_in(iowt), .wake_event_in(wake),
        .gpio_wr_dir_in(wdir), .gpio_wr_val_in(wval), .gpio_wdata_in(wd), .gpio_pin_in(gpin),
        .crossover_in(xo), .fiber_signal_detect_in(fsd), .test_mode_in(tmi), .cfg_out(cfg), .ready_out(rdy),
        .int_o_out(io), .int_oe_out(ioe), .cs_active_high_out(csh), .speed_indicator_o_out(so),
        .speed_indicator_oe_out(soe), .link_activity_indicator_o_out(lo), .link_activity_indicator_oe_out(loe),
        .gpio_o_out(go), .gpio_oe_out(goe), .gpio_value_out(gv), .rx_pair_is_tx_out(rxt),
        .tx_pair_is_rx_out(txr), .fiber_rx_valid_out(fv), .test_mode_seen_out(tms));
    // ****
    // Expectation, compare and closing
    // ****
    function automatic logic [5:0] exp_pins(input logic [3:0] s, input splp_mem_cfg_t m,
                                            input splp_phy_stat_t p, input logic [3:0] ev);
        logic od;
        logic [1:0] sel;
        logic [1:0] lp;
        od = s[2] & s[0];
        sel = s[2] ? ALT_LED : m.link_pin_sel;
        lp = {1'b0, m.led_mode ? p.link_up | p.carrier_sense : p.carrier_sense};
        if (sel == ALT_BUS) begin
            lp = {1'b0, ev[1]};
        end else if (sel == ALT_WAKE) begin
            lp = {ev[0], 1'b1};
        end
        return {od ? {1'b0, ev[3]} : {ev[3] ^ s[3], 1'b1},
                (!s[2] && m.speed_pin_alt) ? {1'b0, ev[2]} : {1'b0, p.speed_100}, lp};
    endfunction
    task automatic check(input string nm, input logic [7:0] x, input logic [7:0] g);
        total_checks++;
        if (g !== x) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        wrap_up();
    end
    initial begin
        n_mismatch = 0;
        total_checks = 0;
        r = $urandom(32'hd05b83a4);
        {rst_b, irq, io16, iowt, wake, wdir, wval, xo, fsd} = 9'h0;
        {fit, word, phy, wd, gpin} = 18'h0;
        repeat (8) @(posedge clk);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            rst_b <= 1'b0;
            fit <= i[3:0];
            word <= splp_mem_cfg_t'({i[3], i[0], (i[1:0] == 2'h3) ? 2'h0 : i[1:0]});
            {wdir, wval, wd} <= 5'h1f;
            gdir = 3'h0;
            gval = 3'h0;
            k = 0;
            repeat (3) @(posedge clk);
            rst_b <= 1'b1;
            while (rdy !== 1'b1 && k < 20) begin
                @(posedge clk);
                k++;
                {wdir, wval} <= (k < RC) ? 2'h3 : 2'h0;
                #1;
            end
            check("ready", 8'(RC), k[7:0]);
            check("gpio_up", 8'h0, {2'h0, go, goe});
            check("strap", 8'(i[3:2]), 8'(cfg[3:2]));
            if (i[2]) check("strap8", 8'(i[1:0]), 8'(cfg[1:0]));
            check("cs", 8'(i[2] & i[1]), 8'(csh));
            repeat (24) begin
                r = $urandom;
                ph = r[17:14];
                @(posedge clk);
                phy <= ph;
                {irq, io16, iowt, wake, xo, fsd, wdir, wval, wd, gpin} <= r[13:0];
                if (r[7]) gdir = r[5:3];
                if (r[6]) gval = r[5:3];
                @(posedge clk);
                #1;
                e = exp_pins(i[3:0], word, ph, r[13:10]);
                check("int", 8'(e[5:4]), {6'h0, io, ioe});
                check("speed", 8'(e[3:2]), {6'h0, so, soe});
                check("link", 8'(e[1:0]), {6'h0, lo, loe});
                check("gpio", {2'h0, gval, gdir}, {2'h0, go, goe});
                check("gpio_rd", {5'h0, (gdir & gval) | (~gdir & r[2:0])}, {5'h0, gv});
                check("pins", {4'h0, r[9], r[9], r[8], 1'b0}, {4'h0, rxt, txr, fv, tms});
            end
            check("hold", 8'(i[3:2]), 8'(cfg[3:2]));
        end
        wrap_up();
    end
endmodule
